/* File: sug_pkg.sv */
// Shared constants and types for the supply undervoltage gating block
package sug_pkg;
   // Channel and pin counts
   localparam int NUM_CH = 8;
   localparam int NUM_PINS = 2;
   // Synchroniser depth for the supply comparator flags
   localparam int SYNC_STAGES = 2;
   // Default pin-to-channel map: pin 0 drives channel 2, pin 1 drives channel 3
   localparam logic [NUM_PINS*NUM_CH-1:0] PIN_MAP_DFLT = 16'h0804;

   // Supply comparator flags, all active high
   typedef struct packed {
      logic ana_uv;       // Analog supply at or below its low threshold
      logic ana_below_op; // Analog supply below its operating threshold
      logic dig_uv;       // Digital supply at or below its low threshold
      logic dig_lop;      // Digital supply at its minimum operating level
   } sug_flags_t;

   // Supply region seen after synchronisation
   typedef enum logic [2:0] {
      SUG_BOTH_UV = 3'h0,
      SUG_DIG_UV = 3'h1,
      SUG_ANA_UV = 3'h2,
      SUG_ANA_LOW = 3'h3,
      SUG_NORMAL = 3'h4
   } sug_region_t;

   // Complete state of the gating module
   typedef struct packed {
      logic [NUM_CH-1:0] ch_on;
      logic regs_reset;
      logic serial_refuse;
      logic serial_cmd_ignore;
      logic fs_allow;
      logic fs_active;
      logic slow_limit;
      sug_region_t region;
   } sug_state_t;

   // Reset state: channels off, serial side held, fail-safe not entered
   localparam sug_state_t SUG_STATE_RST = '{
      ch_on: 8'h00,
      regs_reset: 1'b1,
      serial_refuse: 1'b1,
      serial_cmd_ignore: 1'b1,
      fs_allow: 1'b0,
      fs_active: 1'b0,
      slow_limit: 1'b0,
      region: SUG_BOTH_UV
   };
endpackage

/* File: sug_sync.sv */
// Multi-stage level synchroniser for the supply comparator flags
module sug_sync #(
   parameter int WIDTH = 4,
   parameter int STAGES = sug_pkg::SYNC_STAGES
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage_r [STAGES];

   // Refuse a chain too short to settle metastability
   if (STAGES < 2) begin : g_bad_stages
      $error("sug_sync needs at least two stages");
   end

   // Shift chain, first stage read only by the second
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < STAGES; i++) begin
            stage_r[i] <= '0;
         end
      end else begin
         stage_r[0] <= d;
         for (int i = 1; i < STAGES; i++) begin
            stage_r[i] <= stage_r[i-1];
         end
      end
   end

   assign q = stage_r[STAGES-1];
endmodule // sug_sync

/* File: sug_gating.sv */
// Supply undervoltage gating of channels, serial port and fail-safe mode
//
// How it works
// (R1) Both supplies low: stages off, serial refused, reset
// (R2) Digital low: ignore serial, registers to defaults
// (R3) Analog low: channels off, back on at operating
// (R4) Analog marginal: an off channel stays off
// (R5) Analog marginal: on channels stay until commanded off
// (R6) Digital low, analog above 3 V: pins only
// (R7) Analog at most 3 V, digital not low: fail-safe allowed, channels off
// (R8) Host slows serial clock in low-supply region
// (R9) Good supplies: serial and pins both switch channels
// (R10) Analog at operating: fail-safe always usable
// (R11) Idle low plus pin high enters fail-safe
// (R12) Comparator flags synchronised before use
module sug_gating #(
   parameter int SYNC_STAGES = sug_pkg::SYNC_STAGES,
   parameter logic [sug_pkg::NUM_PINS*sug_pkg::NUM_CH-1:0] PIN_MAP = sug_pkg::PIN_MAP_DFLT
) (
   input wire logic clock,
   input wire logic rstn,
   input sug_pkg::sug_flags_t supply_flags,
   input wire logic [sug_pkg::NUM_PINS-1:0] direct_input_pins,
   input wire logic idle_pin,
   input wire logic [sug_pkg::NUM_CH-1:0] serial_ch_cmd,
   output logic [sug_pkg::NUM_CH-1:0] ch_drive,
   output logic serial_regs_reset,
   output logic serial_refuse,
   output logic serial_cmd_ignore,
   output logic failsafe_allow,
   output logic failsafe_active,
   output logic sclk_slow_limit,
   output sug_pkg::sug_region_t supply_region
);
   sug_pkg::sug_state_t state_r;
   sug_pkg::sug_state_t state_nxt;
   sug_pkg::sug_flags_t flags_s;
   logic [sug_pkg::NUM_CH-1:0] req_w;
   logic fs_allow_w;
   logic fs_active_w;

   // Refuse a map that drives no channel at all
   if (PIN_MAP == '0) begin : g_bad_map
      $error("sug_gating pin map drives no channel");
   end

   // Comparator flags into the clock domain
   sug_sync #(
      .WIDTH($bits(sug_pkg::sug_flags_t)),
      .STAGES(SYNC_STAGES)
   ) u_flag_sync (
      .clock(clock),
      .rstn(rstn),
      .d(supply_flags),
      .q(flags_s)
   ); // R12

   // Region decode, also exported for observation
   function automatic sug_pkg::sug_region_t region_of(input sug_pkg::sug_flags_t f);
      if (f.ana_uv && f.dig_uv) begin
         return sug_pkg::SUG_BOTH_UV;
      end else if (f.dig_uv) begin
         return sug_pkg::SUG_DIG_UV;
      end else if (f.ana_uv) begin
         return sug_pkg::SUG_ANA_UV;
      end else if (f.ana_below_op) begin
         return sug_pkg::SUG_ANA_LOW;
      end else begin
         return sug_pkg::SUG_NORMAL;
      end
   endfunction

   // OR of mapped pins with serial commands when serial is honoured
   function automatic logic [sug_pkg::NUM_CH-1:0] chan_req(
      input logic [sug_pkg::NUM_PINS-1:0] pins,
      input logic [sug_pkg::NUM_CH-1:0] ser,
      input logic ser_ok
   );
      logic [sug_pkg::NUM_CH-1:0] r;
      r = ser_ok ? ser : '0;
      for (int p = 0; p < sug_pkg::NUM_PINS; p++) begin
         if (pins[p]) begin
            r = r | PIN_MAP[p*sug_pkg::NUM_CH +: sug_pkg::NUM_CH];
         end
      end
      return r;
   endfunction

   // Fail-safe availability and entry
   assign fs_allow_w = !(flags_s.ana_uv && flags_s.dig_uv); // R7 R10
   assign fs_active_w = fs_allow_w && !idle_pin && (|direct_input_pins); // R11
   // Serial channel commands dropped on digital low or in fail-safe
   assign req_w = chan_req(direct_input_pins, serial_ch_cmd,
                           !flags_s.dig_uv && !fs_active_w); // R6 R9

   // Next state from synchronised supplies and requests
   always_comb begin
      state_nxt = state_r;
      state_nxt.region = region_of(flags_s);
      state_nxt.regs_reset = flags_s.dig_uv; // R1 R2
      state_nxt.serial_refuse = flags_s.dig_uv; // R1 R2
      state_nxt.serial_cmd_ignore = flags_s.dig_uv || fs_active_w; // R6
      state_nxt.fs_allow = fs_allow_w;
      state_nxt.fs_active = fs_active_w;
      state_nxt.slow_limit = flags_s.dig_lop && flags_s.ana_below_op && !flags_s.dig_uv; // R8
      case (state_nxt.region)
         sug_pkg::SUG_BOTH_UV, sug_pkg::SUG_ANA_UV: begin
            state_nxt.ch_on = '0; // R1 R3 R7
         end
         default: begin
            if (flags_s.ana_below_op) begin
               state_nxt.ch_on = state_r.ch_on & req_w; // R4 R5
            end else begin
               state_nxt.ch_on = req_w; // R3 R9
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= sug_pkg::SUG_STATE_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs straight from the state register
   assign ch_drive = state_r.ch_on;
   assign serial_regs_reset = state_r.regs_reset;
   assign serial_refuse = state_r.serial_refuse;
   assign serial_cmd_ignore = state_r.serial_cmd_ignore;
   assign failsafe_allow = state_r.fs_allow;
   assign failsafe_active = state_r.fs_active;
   assign sclk_slow_limit = state_r.slow_limit;
   assign supply_region = state_r.region;

   // Supply conditions and the fail-safe request as named sequences
   sequence both_low_s;
      flags_s.ana_uv && flags_s.dig_uv;
   endsequence

   sequence ana_marginal_s;
      flags_s.ana_below_op && !flags_s.ana_uv;
   endsequence

   sequence ana_good_s;
      !flags_s.ana_below_op && !flags_s.ana_uv;
   endsequence

   sequence fs_request_s;
      fs_allow_w && !idle_pin && (|direct_input_pins);
   endsequence

   both_low_off_a: assert property (@(posedge clock) disable iff (!rstn) // R1
      both_low_s |=> (ch_drive == '0) && serial_refuse && serial_regs_reset && !failsafe_allow)
      else $error("both supplies low but block not shut down");

   dig_low_reset_a: assert property (@(posedge clock) disable iff (!rstn) // R2
      flags_s.dig_uv |=> serial_regs_reset && serial_refuse)
      else $error("digital supply low but serial side not held");

   ana_low_off_a: assert property (@(posedge clock) disable iff (!rstn) // R3
      flags_s.ana_uv |=> ch_drive == '0)
      else $error("analog supply low but a channel is on");

   no_turn_on_a: assert property (@(posedge clock) disable iff (!rstn) // R4
      ana_marginal_s |=> (ch_drive & ~$past(ch_drive)) == '0)
      else $error("channel turned on in marginal analog region");

   keep_on_a: assert property (@(posedge clock) disable iff (!rstn) // R5
      ana_marginal_s |=> ch_drive == ($past(ch_drive) & $past(req_w)))
      else $error("on channel not held in marginal analog region");

   pins_only_a: assert property (@(posedge clock) disable iff (!rstn) // R6
      (flags_s.dig_uv && !flags_s.ana_uv && !flags_s.ana_below_op) |=>
         serial_cmd_ignore && (ch_drive == $past(chan_req(direct_input_pins, '0, 1'b0))))
      else $error("serial command acted on while digital supply low");

   ana3v_failsafe_a: assert property (@(posedge clock) disable iff (!rstn) // R7
      (flags_s.ana_uv && !flags_s.dig_uv) |=> failsafe_allow && (ch_drive == '0) && !serial_regs_reset)
      else $error("fail-safe or registers wrong with analog at 3 V");

   slow_clock_a: assert property (@(posedge clock) disable iff (!rstn) // R8
      (flags_s.dig_lop && flags_s.ana_below_op && !flags_s.dig_uv) |=> sclk_slow_limit)
      else $error("slow serial clock limit not flagged");

   good_switch_a: assert property (@(posedge clock) disable iff (!rstn) // R9
      ana_good_s ##1 ana_good_s |-> ch_drive == $past(req_w) && failsafe_allow)
      else $error("channels do not follow requests with good supplies");

   fs_usable_a: assert property (@(posedge clock) disable iff (!rstn) // R10
      ana_good_s |=> failsafe_allow)
      else $error("fail-safe unusable with analog at operating level");

   fs_entry_a: assert property (@(posedge clock) disable iff (!rstn) // R11
      fs_request_s |=> failsafe_active && serial_cmd_ignore)
      else $error("fail-safe not entered on idle low with pin high");

   // Analog supply in its low band
   sequence ana_low_s;
      flags_s.ana_uv;
   endsequence

   // Channels come back by themselves after a low spell
   reenable_a: assert property (@(posedge clock) disable iff (!rstn) // R3
      ana_low_s ##1 ana_good_s |=> ch_drive == $past(req_w))
      else $error("channels not re-enabled after analog low");

   // With digital low no channel runs beyond what the pins ask
   pin_bound_a: assert property (@(posedge clock) disable iff (!rstn) // R6
      flags_s.dig_uv |=>
         (ch_drive & ~$past(chan_req(direct_input_pins, '0, 1'b0))) == '0)
      else $error("channel on without a pin request while digital supply low");

   // Flags reach the decode exactly the chain depth late
   sync_delay_a: assert property (@(posedge clock) disable iff (!rstn) // R12
      $past(rstn, SYNC_STAGES) |-> flags_s == $past(supply_flags, SYNC_STAGES))
      else $error("comparator flags not delayed by the synchroniser depth");
endmodule // sug_gating

/* File: sug_host_model.sv */
// Host controller model driving the direct pins, idle pin and serial channel commands
module sug_host_model (
   input wire logic clock,
   input wire logic [1:0] want_pins,
   input wire logic want_idle,
   input wire logic [7:0] want_ser,
   input wire logic sclk_slow_limit,
   output logic [1:0] direct_input_pins,
   output logic idle_pin,
   output logic [7:0] serial_ch_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   int sclk_mhz;
   // Pin and command levels change only on the falling edge
   always @(negedge clock) begin
      direct_input_pins <= want_pins;
      idle_pin <= want_idle;
      serial_ch_cmd <= want_ser;
      sclk_mhz <= sclk_slow_limit ? 1 : 5;
   end
endmodule // sug_host_model

/* File: tb.sv */
// Self-checking testbench for the supply undervoltage gating block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   sug_pkg::sug_flags_t supply_flags = '0;
   logic [1:0] want_pins = 2'h0;
   logic want_idle = 1'b1;
   logic [7:0] want_ser = 8'h00;
   logic [1:0] direct_input_pins;
   logic idle_pin;
   logic [7:0] serial_ch_cmd;
   logic [7:0] ch_drive;
   logic serial_regs_reset, serial_refuse, serial_cmd_ignore;
   logic failsafe_allow, failsafe_active, sclk_slow_limit;
   sug_pkg::sug_region_t supply_region;
   int fails = 0;
   int n_tests = 0;
   int seed = 32'hbb90;
   logic [16:0] exp_q[$];
   logic [7:0] exp_ch = 8'h00;
   sug_pkg::sug_flags_t rf;
   logic [16:0] seen_out;
   event check_ev;
   // Free-running clock
   always #5 clock = ~clock;
   sug_gating dut_u (.clock(clock), .rstn(rstn), .supply_flags(supply_flags),
      .direct_input_pins(direct_input_pins), .idle_pin(idle_pin), .serial_ch_cmd(serial_ch_cmd),
      .ch_drive(ch_drive), .serial_regs_reset(serial_regs_reset), .serial_refuse(serial_refuse),
      .serial_cmd_ignore(serial_cmd_ignore), .failsafe_allow(failsafe_allow),
      .failsafe_active(failsafe_active), .sclk_slow_limit(sclk_slow_limit), .supply_region(supply_region));
   sug_host_model host_u (.clock(clock), .want_pins(want_pins), .want_idle(want_idle), .want_ser(want_ser),
      .sclk_slow_limit(sclk_slow_limit), .direct_input_pins(direct_input_pins), .idle_pin(idle_pin),
      .serial_ch_cmd(serial_ch_cmd));
   // Expected settled outputs for one change of inputs
   function automatic logic [16:0] expect_out(input sug_pkg::sug_flags_t f, input logic [1:0] p,
      input logic idl, input logic [7:0] s);
      logic fsa, fsr;
      logic [7:0] req, ch;
      logic [2:0] rg;
      fsa = !(f.ana_uv && f.dig_uv);
      fsr = fsa && !idl && (|p);
      req = (p[0] ? 8'h04 : 8'h00) | (p[1] ? 8'h08 : 8'h00) | ((!f.dig_uv && !fsr) ? s : 8'h00);
      ch = f.ana_uv ? 8'h00 : (f.ana_below_op ? (exp_ch & req) : req);
      rg = (f.ana_uv && f.dig_uv) ? 3'h0 : f.dig_uv ? 3'h1 : f.ana_uv ? 3'h2 : f.ana_below_op ? 3'h3 : 3'h4;
      exp_ch = ch;
      return {ch, f.dig_uv, f.dig_uv, f.dig_uv || fsr, fsa, fsr, f.dig_lop && f.ana_below_op && !f.dig_uv, rg};
   endfunction
   // Compare all outputs against the oldest note
   task automatic cmp_out(input logic [16:0] exp, input logic [16:0] seen);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value outputs expected %h seen %h", exp, seen);
      end
   endtask
   // Drive one input change, note the expectation, let it settle
   task automatic step(input sug_pkg::sug_flags_t f, input logic [1:0] p, input logic i, input logic [7:0] s);
      @(negedge clock);
      supply_flags = f;
      want_pins = p;
      want_idle = i;
      want_ser = s;
      exp_q.push_back(expect_out(f, p, i, s));
      repeat (6) @(posedge clock);
      #1 ->check_ev;
   endtask
   task automatic tally_and_finish;
      if (fails == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // All outputs gathered in the order of the notes
   assign seen_out = {ch_drive, serial_regs_reset, serial_refuse, serial_cmd_ignore,
      failsafe_allow, failsafe_active, sclk_slow_limit, supply_region};
   // Output watcher
   always @(check_ev) begin
      cmp_out(exp_q.pop_front(), seen_out);
   end
   // Watchdog
   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clock);
      exp_q.push_back(17'h001C0);
      #1 ->check_ev;
      repeat (10) @(posedge clock);
      @(negedge clock);
      rstn = 1'b1;
      step(4'h0, 2'h0, 1'b1, 8'hFF);
      step(4'h4, 2'h0, 1'b1, 8'hFF);
      step(4'h4, 2'h0, 1'b1, 8'h0F);
      step(4'h4, 2'h1, 1'b1, 8'hFF);
      step(4'hC, 2'h1, 1'b1, 8'hFF);
      step(4'h0, 2'h1, 1'b1, 8'hFF);
      step(4'h2, 2'h1, 1'b1, 8'hF0);
      step(4'h2, 2'h2, 1'b0, 8'hF0);
      step(4'hE, 2'h2, 1'b0, 8'hF0);
      step(4'h9, 2'h3, 1'b0, 8'h55);
      for (int k = 0; k < 300; k++) begin
         rf = sug_pkg::sug_flags_t'(4'($random(seed)));
         rf.ana_below_op = rf.ana_below_op | rf.ana_uv;
         if (rf.dig_uv) rf.dig_lop = 1'b0;
         if (k % 2 == 0) step(rf, want_pins, want_idle, want_ser);
         else step(supply_flags, 2'($random(seed)), 1'($random(seed)), 8'($random(seed)));
      end
      tally_and_finish();
   end
endmodule // tb
